// ### rtl/usf_serial_engine.sv
// Asynchronous serial frame engine with AXI4-Lite register access
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
module usf_serial_engine
	import usf_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// AXI4-Lite write address and data
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address and data
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Processor global interrupt mask and request
	input wire logic globalIrqMask,
	output logic irqReq,
	// Serial pins
	input wire logic serialInPin,
	output logic serialOut,
	output logic serialOutEnN
);
	usf_state_type s_r;
	usf_state_type s_nxt;
	logic [10:0] txLimit;
	logic [10:0] rxLimit;
	logic txTick;
	logic rxTick;
	logic wrDo;
	logic [8:0] txWord;
	logic [2:0] samp;
	logic majority;
	logic noisy;
	logic [8:0] rxWord;
	logic rxParityBad;
	logic [3:0] dataBits;
	logic [31:0] readMux;
	logic [1:0] readResp;

	// Tick period in clocks is prescaler times power-of-two divider
	function automatic logic [10:0] baudLimit(input logic [1:0] pre, input logic [2:0] ex);
		logic [10:0] p;
		unique case (pre)
			2'h0: p = PRE_0;
			2'h1: p = PRE_1;
			2'h2: p = PRE_2;
			2'h3: p = PRE_3;
		endcase
		return (p << ex) - 11'h001;
	endfunction

	// Independent dividers, each feeding its own 16x oversample tick
	assign txLimit = baudLimit(s_r.baud[BD_PRE_LO +: 2], s_r.baud[BD_TX_LO +: 3]);
	assign rxLimit = baudLimit(s_r.baud[BD_PRE_LO +: 2], s_r.baud[BD_RX_LO +: 3]);
	assign txTick = (s_r.txCnt == txLimit);
	assign rxTick = (s_r.rxCnt == rxLimit);
	assign wrDo = s_r.awHave && s_r.wHave;
	assign dataBits = s_r.ctrl1[C1_WORD9] ? 4'h9 : 4'h8;

	// Held word with parity replacing the top data bit when enabled
	always_comb begin
		txWord = s_r.holdData;
		if (s_r.ctrl1[C1_PARITYEN]) begin
			if (s_r.ctrl1[C1_WORD9]) begin
				txWord[8] = ^s_r.holdData[7:0] ^ s_r.ctrl1[C1_PARITYSEL];
			end else begin
				txWord[7] = ^s_r.holdData[6:0] ^ s_r.ctrl1[C1_PARITYSEL];
			end
		end
	end

	// Three-sample majority vote over samples 8, 9 and 10
	assign samp = {s_r.rxSamp, s_r.rxSync};
	assign majority = (samp[0] & samp[1]) | (samp[0] & samp[2]) | (samp[1] & samp[2]);
	assign noisy = !(samp == 3'h0 || samp == 3'h7);

	// Received word aligned to bit 0; 8-bit frames leave it in the top bits
	assign rxWord = s_r.ctrl1[C1_WORD9] ? s_r.rxShift : {1'b0, s_r.rxShift[8:1]};
	assign rxParityBad = s_r.ctrl1[C1_PARITYEN] && ((^rxWord) != s_r.ctrl1[C1_PARITYSEL]);

	// Read data selection; unmapped addresses answer with an error
	always_comb begin
		readMux = 32'h0000_0000;
		readResp = RESP_OKAY;
		unique case (s_axi_araddr)
			ADDR_STATUS: readMux[7:0] = s_r.status;
			ADDR_DATA: readMux[7:0] = s_r.rxBuf;
			ADDR_CTRL1: begin
				readMux[7:0] = s_r.ctrl1;
				readMux[C1_RXNINTH] = s_r.rxNinth;
			end
			ADDR_CTRL2: readMux[7:0] = s_r.ctrl2;
			ADDR_BAUD: readMux[7:0] = s_r.baud;
			default: readResp = RESP_SLVERR;
		endcase
	end

	// Next state of the whole block
	always_comb begin
		s_nxt = s_r;
		// Pin synchroniser: the first stage feeds only the second
		s_nxt.rxMeta = serialInPin;
		s_nxt.rxSync = s_r.rxMeta;
		s_nxt.txCnt = txTick ? 11'h000 : s_r.txCnt + 11'h001;
		s_nxt.rxCnt = rxTick ? 11'h000 : s_r.rxCnt + 11'h001;

		// Write address and data are taken independently, in either order
		if (s_r.awReady && s_axi_awvalid) begin
			s_nxt.awReady = 1'b0;
			s_nxt.awHave = 1'b1;
			s_nxt.wAddr = s_axi_awaddr;
		end
		if (s_r.wReady && s_axi_wvalid) begin
			s_nxt.wReady = 1'b0;
			s_nxt.wHave = 1'b1;
			s_nxt.wData = s_axi_wdata;
			s_nxt.wStrb = s_axi_wstrb;
		end
		if (wrDo) begin
			s_nxt.awHave = 1'b0;
			s_nxt.wHave = 1'b0;
			s_nxt.bValid = 1'b1;
			s_nxt.bResp = RESP_OKAY;
			unique case (s_r.wAddr)
				ADDR_STATUS: begin
					s_nxt.bResp = RESP_OKAY;
				end
				ADDR_DATA: begin
					if (s_r.wStrb[0]) begin
						// Word waits here until the shifter is free
						s_nxt.holdData = {s_r.ctrl1[C1_TXNINTH], s_r.wData[7:0]};
						s_nxt.holdFull = 1'b1;
						if (s_r.statusSeen) begin
							s_nxt.status[ST_TXEMPTY] = 1'b0;
							s_nxt.status[ST_TXDONE] = 1'b0;
						end
						s_nxt.statusSeen = 1'b0;
					end
				end
				ADDR_CTRL1: begin
					if (s_r.wStrb[0]) begin
						s_nxt.ctrl1 = s_r.wData[7:0] & 8'h56;
					end
				end
				ADDR_CTRL2: begin
					if (s_r.wStrb[0]) begin
						s_nxt.ctrl2 = s_r.wData[7:0] & 8'hfd;
					end
				end
				ADDR_BAUD: begin
					if (s_r.wStrb[0]) begin
						s_nxt.baud = s_r.wData[7:0];
					end
				end
				default: s_nxt.bResp = RESP_SLVERR;
			endcase
		end
		if (s_r.bValid && s_axi_bready) begin
			s_nxt.bValid = 1'b0;
			s_nxt.awReady = 1'b1;
			s_nxt.wReady = 1'b1;
		end

		// Reads answer one cycle after the address is taken
		if (s_r.arReady && s_axi_arvalid) begin
			s_nxt.arReady = 1'b0;
			s_nxt.rValid = 1'b1;
			s_nxt.rData = readMux;
			s_nxt.rResp = readResp;
			if (s_axi_araddr == ADDR_STATUS) begin
				s_nxt.statusSeen = 1'b1;
			end
			if (s_axi_araddr == ADDR_DATA && s_r.statusSeen) begin
				s_nxt.status[ST_RXFULL] = 1'b0;
				s_nxt.status[ST_OVERRUN] = 1'b0;
				s_nxt.status[ST_NOISE] = 1'b0;
				s_nxt.status[ST_FRAMING] = 1'b0;
				s_nxt.status[ST_PARITY] = 1'b0;
				s_nxt.status[ST_IDLE] = 1'b0;
				s_nxt.statusSeen = 1'b0;
			end
		end
		if (s_r.rValid && s_axi_rready) begin
			s_nxt.rValid = 1'b0;
			s_nxt.arReady = 1'b1;
		end

		// Enable rising edge queues an idle frame and drops a held word
		s_nxt.txEnPrev = s_r.ctrl2[C2_TXEN];
		if (s_r.ctrl2[C2_TXEN] && !s_r.txEnPrev) begin
			s_nxt.idlePending = 1'b1;
			s_nxt.holdFull = 1'b0;
			s_nxt.status[ST_TXEMPTY] = 1'b1;
		end

		// Transmitter: the hardware sets below win over software clears above
		unique case (s_r.txState)
			TX_QUIET: begin
				if (s_r.ctrl2[C2_TXEN]) begin
					s_nxt.txSub = 4'h0;
					s_nxt.txCnt = 11'h000;
					s_nxt.txBits = s_r.ctrl1[C1_WORD9] ? FRAME_BITS9 : FRAME_BITS8;
					if (s_r.idlePending || s_nxt.idlePending) begin
						s_nxt.idlePending = 1'b0;
						s_nxt.txShift = 11'h7ff;
						s_nxt.txEndsWord = 1'b0;
						s_nxt.txState = TX_SHIFT;
					end else if (s_r.ctrl2[C2_BREAK]) begin
						s_nxt.txShift = 11'h000;
						s_nxt.txWasBreak = 1'b1;
						s_nxt.txEndsWord = 1'b1;
						s_nxt.txState = TX_SHIFT;
					end else if (s_r.txWasBreak) begin
						// Single mark after the last break frame
						s_nxt.txShift = 11'h7ff;
						s_nxt.txBits = 4'h1;
						s_nxt.txWasBreak = 1'b0;
						s_nxt.txEndsWord = 1'b0;
						s_nxt.txState = TX_SHIFT;
					end else if (s_r.holdFull) begin
						// Stop high, data LSB first, start low
						if (s_r.ctrl1[C1_WORD9]) begin
							s_nxt.txShift = {1'b1, txWord, 1'b0};
						end else begin
							s_nxt.txShift = {2'h3, txWord[7:0], 1'b0};
						end
						s_nxt.holdFull = 1'b0;
						s_nxt.status[ST_TXEMPTY] = 1'b1;
						s_nxt.txEndsWord = 1'b1;
						s_nxt.txState = TX_SHIFT;
					end
				end
			end
			TX_SHIFT: begin
				if (txTick) begin
					s_nxt.txSub = s_r.txSub + 4'h1;
					if (s_r.txSub == SUB_LAST) begin
						s_nxt.txShift = {1'b1, s_r.txShift[10:1]};
						s_nxt.txBits = s_r.txBits - 4'h1;
						if (s_r.txBits == 4'h1) begin
							s_nxt.txState = TX_QUIET;
							if (s_r.txEndsWord) begin
								s_nxt.status[ST_TXDONE] = 1'b1;
							end
						end
					end
				end
			end
		endcase

		// Receiver: hunts for a low sample, then votes every bit
		if (!s_r.ctrl2[C2_RXEN]) begin
			s_nxt.rxState = RX_HUNT;
			s_nxt.idleArmed = 1'b1;
			s_nxt.idleCnt = 8'h00;
		end else if (rxTick) begin
			unique case (s_r.rxState)
				RX_HUNT: begin
					if (!s_r.rxSync) begin
						s_nxt.rxState = RX_FRAME;
						s_nxt.rxSub = 4'h1;
						s_nxt.rxIdx = 4'h0;
						s_nxt.idleCnt = 8'h00;
					end else if (s_r.idleArmed) begin
						s_nxt.idleCnt = s_r.idleCnt + 8'h01;
						// A whole frame time of ones counts as one idle character
						if (s_r.idleCnt == (s_r.ctrl1[C1_WORD9] ? IDLE_TICKS9 : IDLE_TICKS8)) begin
							s_nxt.status[ST_IDLE] = 1'b1;
							s_nxt.idleArmed = 1'b0;
							s_nxt.idleCnt = 8'h00;
						end
					end
				end
				RX_FRAME: begin
					s_nxt.rxSub = s_r.rxSub + 4'h1;
					if (s_r.rxSub >= SAMP_FIRST && s_r.rxSub < SAMP_LAST) begin
						s_nxt.rxSamp = {s_r.rxSamp[0], s_r.rxSync};
					end
					if (s_r.rxSub == SAMP_LAST) begin
						if (s_r.rxIdx == 4'h0) begin
							// A false start is dropped; its noise shows with the next character
							s_nxt.rxNoise = s_r.rxNoise | noisy;
							if (majority) begin
								s_nxt.rxState = RX_HUNT;
							end
						end else if (s_r.rxIdx <= dataBits) begin
							s_nxt.rxShift = {majority, s_r.rxShift[8:1]};
							s_nxt.rxNoise = s_r.rxNoise | noisy;
						end else begin
							// Stop sampled: end early to leave room for clock drift
							s_nxt.rxState = RX_HUNT;
							s_nxt.idleArmed = 1'b1;
							s_nxt.rxNoise = 1'b0;
							if (s_nxt.status[ST_RXFULL]) begin
								s_nxt.status[ST_OVERRUN] = 1'b1;
							end else begin
								s_nxt.rxBuf = rxWord[7:0];
								s_nxt.rxNinth = s_r.ctrl1[C1_WORD9] & rxWord[8];
								s_nxt.status[ST_RXFULL] = 1'b1;
								s_nxt.status[ST_FRAMING] = !majority;
								s_nxt.status[ST_NOISE] = s_r.rxNoise | noisy;
								s_nxt.status[ST_PARITY] = rxParityBad;
							end
						end
					end
					if (s_r.rxSub == SUB_LAST) begin
						s_nxt.rxSub = 4'h0;
						s_nxt.rxIdx = s_r.rxIdx + 4'h1;
					end
				end
			endcase
		end

		// Pin belongs to the block while either direction is enabled
		s_nxt.serialOutEnN = !(s_nxt.ctrl2[C2_TXEN] || s_nxt.ctrl2[C2_RXEN]);
		s_nxt.serialOut = (s_nxt.txState == TX_SHIFT) ? s_nxt.txShift[0] :
			!(s_nxt.ctrl2[C2_TXEN] && s_nxt.ctrl2[C2_BREAK] && s_nxt.txWasBreak);
		// One request line, gated by the processor mask
		s_nxt.irqReq = !globalIrqMask && (
			(s_nxt.status[ST_TXEMPTY] && s_nxt.ctrl2[C2_TXEIE]) ||
			(s_nxt.status[ST_TXDONE] && s_nxt.ctrl2[C2_TX_COMPLETE_IRQ_ENABLE]) ||
			((s_nxt.status[ST_RXFULL] || s_nxt.status[ST_OVERRUN]) &&
				s_nxt.ctrl2[C2_RIE]) ||
			(s_nxt.status[ST_IDLE] && s_nxt.ctrl2[C2_IDLE_LINE_IRQ_ENABLE]));
	end

	// State register with synchronous reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			s_r <= '0;
			s_r.awReady <= 1'b1;
			s_r.wReady <= 1'b1;
			s_r.arReady <= 1'b1;
			s_r.baud <= BAUD_RESET;
			s_r.status[ST_TXEMPTY] <= 1'b1;
			s_r.status[ST_TXDONE] <= 1'b1;
			s_r.rxMeta <= 1'b1;
			s_r.rxSync <= 1'b1;
			s_r.serialOut <= 1'b1;
			s_r.serialOutEnN <= 1'b1;
			s_r.txState <= TX_QUIET;
			s_r.rxState <= RX_HUNT;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign s_axi_awready = s_r.awReady;
	assign s_axi_wready = s_r.wReady;
	assign s_axi_bvalid = s_r.bValid;
	assign s_axi_bresp = s_r.bResp;
	assign s_axi_arready = s_r.arReady;
	assign s_axi_rvalid = s_r.rValid;
	assign s_axi_rdata = s_r.rData;
	assign s_axi_rresp = s_r.rResp;
	assign irqReq = s_r.irqReq;
	assign serialOut = s_r.serialOut;
	assign serialOutEnN = s_r.serialOutEnN;
endmodule

// ### rtl/usf_pkg.sv
// Package for the asynchronous serial frame engine: register map, fields, types
package usf_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_DATA = 8'h04;
	localparam logic [7:0] ADDR_CTRL1 = 8'h08;
	localparam logic [7:0] ADDR_CTRL2 = 8'h0c;
	localparam logic [7:0] ADDR_BAUD = 8'h10;
	// Status field positions
	localparam int ST_TXEMPTY = 7;
	localparam int ST_TXDONE = 6;
	localparam int ST_RXFULL = 5;
	localparam int ST_IDLE = 4;
	localparam int ST_OVERRUN = 3;
	localparam int ST_NOISE = 2;
	localparam int ST_FRAMING = 1;
	localparam int ST_PARITY = 0;
	// Control one field positions
	localparam int C1_RXNINTH = 7;
	localparam int C1_TXNINTH = 6;
	localparam int C1_WORD9 = 4;
	localparam int C1_PARITYEN = 2;
	localparam int C1_PARITYSEL = 1;
	// Control two field positions
	localparam int C2_TXEIE = 7;
	localparam int C2_TX_COMPLETE_IRQ_ENABLE = 6;
	localparam int C2_RIE = 5;
	localparam int C2_IDLE_LINE_IRQ_ENABLE = 4;
	localparam int C2_TXEN = 3;
	localparam int C2_RXEN = 2;
	localparam int C2_BREAK = 0;
	// Baud select fields: common prescaler, tx and rx power-of-two dividers
	localparam int BD_PRE_LO = 0;
	localparam int BD_TX_LO = 2;
	localparam int BD_RX_LO = 5;
	// Reset values
	localparam logic [7:0] BAUD_RESET = 8'h00;
	// Common prescaler values 1, 3, 4, 13
	localparam logic [10:0] PRE_0 = 11'h001;
	localparam logic [10:0] PRE_1 = 11'h003;
	localparam logic [10:0] PRE_2 = 11'h004;
	localparam logic [10:0] PRE_3 = 11'h00d;
	// Oversampling: 16 ticks per bit, majority of samples 8, 9, 10
	localparam logic [3:0] SUB_LAST = 4'hf;
	localparam logic [3:0] SAMP_FIRST = 4'h7;
	localparam logic [3:0] SAMP_LAST = 4'h9;
	// Frame lengths in bits and idle detection length in ticks
	localparam logic [3:0] FRAME_BITS8 = 4'ha;
	localparam logic [3:0] FRAME_BITS9 = 4'hb;
	localparam logic [7:0] IDLE_TICKS8 = 8'h9f;
	localparam logic [7:0] IDLE_TICKS9 = 8'haf;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {TX_QUIET, TX_SHIFT} usf_tx_type;
	typedef enum logic {RX_HUNT, RX_FRAME} usf_rx_type;

	typedef struct packed {
		logic awReady;
		logic wReady;
		logic awHave;
		logic wHave;
		logic [7:0] wAddr;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic arReady;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic statusSeen;
		logic [7:0] ctrl1;
		logic [7:0] ctrl2;
		logic [7:0] baud;
		logic [7:0] status;
		logic rxNinth;
		logic [7:0] rxBuf;
		logic txEnPrev;
		logic idlePending;
		logic holdFull;
		logic [8:0] holdData;
		usf_tx_type txState;
		logic [10:0] txShift;
		logic [3:0] txBits;
		logic [3:0] txSub;
		logic txWasBreak;
		logic txEndsWord;
		logic [10:0] txCnt;
		logic rxMeta;
		logic rxSync;
		usf_rx_type rxState;
		logic [3:0] rxSub;
		logic [3:0] rxIdx;
		logic [8:0] rxShift;
		logic [1:0] rxSamp;
		logic rxNoise;
		logic [10:0] rxCnt;
		logic idleArmed;
		logic [7:0] idleCnt;
		logic serialOut;
		logic serialOutEnN;
		logic irqReq;
	} usf_state_type;
endpackage

// ### sim/usf_serial_engine_sva.sv
// Port checker for the serial frame engine
module usf_serial_engine_sva (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Interrupt and serial pins
	input wire logic globalIrqMask,
	input wire logic irqReq,
	input wire logic serialOut,
	input wire logic serialOutEnN
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// Bus transfers taken at one edge
	sequence writeTake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence readTake;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// Any bit cell is at least 16 clocks, so half a cell is a safe floor
	sequence lowHalfCell;
		(!serialOut) [*8];
	endsequence
	sequence highHalfCell;
		serialOut [*8];
	endsequence
	chk_mask_quiet: assert property (globalIrqMask |=> !irqReq)
		else $error("interrupt raised while masked");
	chk_low_width: assert property ($fell(serialOut) |-> lowHalfCell)
		else $error("low cell on serial output too short");
	chk_high_width: assert property ($rose(serialOut) |-> highHalfCell)
		else $error("high cell on serial output too short");
	chk_pin_owned: assert property ($fell(serialOut) |-> !serialOutEnN)
		else $error("serial output toggled without owning the pin");
	chk_write_answer: assert property (writeTake |-> ##2 s_axi_bvalid)
		else $error("write response late");
	chk_read_answer: assert property (readTake |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
		else $error("read data late or upper bits set");
	chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	chk_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("second write accepted before response");
endmodule

bind usf_serial_engine usf_serial_engine_sva i_usf_serial_engine_sva (
	.mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .globalIrqMask, .irqReq,
	.serialOut, .serialOutEnN
);

// ### sim/usf_line_partner.sv
// Far-end serial device: sends frames on its line and captures ours
module usf_line_partner (
	// Clock
	input wire logic mclk,
	// Serial lines
	input wire logic txLine,
	output logic rxLine
);
	timeunit 1ns;
	timeprecision 1ps;
	int bitClks = 16;
	int nbits = 8;
	logic [9:0] gotQ[$];
	// Line has a pull-up, so released means high
	initial rxLine = 1'b1;
	// One frame; a zero stop bit fakes a framing fault or a break
	task automatic send_frame(input logic [8:0] w, input int nb, input logic stopBit);
		rxLine <= 1'b0;
		repeat (bitClks) @(posedge mclk);
		for (int i = 0; i < nb; i++) begin
			rxLine <= w[i];
			repeat (bitClks) @(posedge mclk);
		end
		rxLine <= stopBit;
		repeat (bitClks) @(posedge mclk);
		rxLine <= 1'b1;
	endtask
	// Capture at mid-cell; a start that is gone by then is ignored
	initial forever begin
		logic [8:0] w;
		@(negedge txLine);
		repeat (bitClks / 2) @(posedge mclk);
		if (txLine === 1'b0) begin
			w = '0;
			for (int i = 0; i < nbits; i++) begin
				repeat (bitClks) @(posedge mclk);
				w[i] = txLine;
			end
			repeat (bitClks) @(posedge mclk);
			gotQ.push_back({txLine, w});
		end
	end
endmodule

// ### sim/usf_serial_engine_tb.sv
// Self-checking bench for the serial frame engine
module usf_serial_engine_tb import usf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, globalIrqMask, irqReq, serialInPin, serialOut, serialOutEnN;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed;
	logic [3:0] s_axi_wstrb;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int errorCnt = 0;
	int samplesChecked = 0;

	usf_serial_engine i_usf_serial_engine (
		.mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
		.globalIrqMask, .irqReq, .serialInPin, .serialOut, .serialOutEnN
	);
	usf_line_partner i_usf_line_partner (.mclk(mclk), .txLine(serialOut), .rxLine(serialInPin));

	// 250 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Expected captured frame {stop, word}; parity takes the top data bit
	function automatic logic [9:0] expWord(input logic [7:0] c1, input logic [7:0] d);
		logic [8:0] w;
		w = {c1[C1_TXNINTH] & c1[C1_WORD9], d};
		if (c1[C1_PARITYEN] && c1[C1_WORD9]) w[8] = ^d ^ c1[C1_PARITYSEL];
		else if (c1[C1_PARITYEN]) w[7] = ^d[6:0] ^ c1[C1_PARITYSEL];
		return {1'b1, w};
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		samplesChecked++;
		if (got !== exp) begin
			errorCnt++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask

	task automatic reportAndStop();
		$display("checks %0d errors %0d", samplesChecked, errorCnt);
		if (errorCnt == 0 && samplesChecked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// Address and data offered together; each dropped once taken
	task automatic axiWrite(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
		logic aw, w, b;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b) begin
			@(posedge mclk);
			if (s_axi_bvalid && !aw && !w) begin
				b = 1'b1;
				s_axi_bready <= 1'b0;
				check({30'h0, s_axi_bresp}, {30'h0, resp}, "write response");
			end
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
	endtask

	task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string msg);
		logic [31:0] d;
		logic [1:0] r;
		axiRead(a, d, r);
		check(d & {24'h0, m}, {24'h0, e}, msg);
	endtask

	// Status access arms the clear, then the data write
	task automatic sendTx(input logic [7:0] v);
		logic [31:0] d;
		logic [1:0] r;
		axiRead(ADDR_STATUS, d, r);
		axiWrite(ADDR_DATA, v, RESP_OKAY);
	endtask

	task automatic waitGot(input int n);
		int t;
		t = 0;
		while (i_usf_line_partner.gotQ.size() < n && t < 4000) begin
			@(posedge mclk);
			t++;
		end
		repeat (20) @(posedge mclk);
	endtask

	task automatic popChk(input logic [9:0] e, input string msg);
		logic [9:0] g;
		g = ~e;
		if (i_usf_line_partner.gotQ.size() > 0) g = i_usf_line_partner.gotQ.pop_front();
		check({22'h0, g}, {22'h0, e}, msg);
	endtask

	task automatic rxByte(input logic [7:0] v, input logic stopBit);
		@(posedge mclk);
		i_usf_line_partner.send_frame({1'b0, v}, 8, stopBit);
		repeat (20) @(posedge mclk);
	endtask

	// Hang guard, far beyond the few thousand cycles the run needs
	initial begin
		repeat (40000) @(posedge mclk);
		errorCnt++;
		$display("unexpected at %0t: watchdog expired", $time);
		reportAndStop();
	end

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] c1;
		logic [7:0] modes [5];
		realtime t0;
		int t;
		modes = '{8'h00, 8'h50, 8'h10, 8'h04, 8'h16};
		seed = 32'd18;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hf;
		globalIrqMask = 1'b1;
		rst = 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rdChk(ADDR_STATUS, 8'hff, 8'hc0, "status reset value");
		for (int i = 2; i < 5; i++) rdChk(8'(4 * i), 8'hff, 8'h00, "control reset value");
		axiRead(8'h14, d, r);
		check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
		axiWrite(8'h14, 8'hff, RESP_SLVERR);
		axiWrite(ADDR_CTRL2, 8'h0c, RESP_OKAY);
		t0 = $realtime;
		// Five word formats: 8, 9 with both ninth values, 8-bit even and 9-bit odd parity
		foreach (modes[i]) begin
			c1 = modes[i];
			axiWrite(ADDR_CTRL1, c1, RESP_OKAY);
			i_usf_line_partner.nbits = c1[C1_WORD9] ? 9 : 8;
			d = xs();
			sendTx(d[7:0]);
			if (i == 0) begin
				while (serialOut !== 1'b0 && $realtime - t0 < 4000.0) @(posedge mclk);
				check({31'h0, ($realtime - t0) >= 600.0}, 32'h1, "idle frame first");
				check({31'h0, serialOutEnN}, 32'h0, "pin not taken");
			end
			waitGot(1);
			popChk(expWord(c1, d[7:0]), "transmitted frame");
		end
		// Second word queues behind the first
		axiWrite(ADDR_CTRL1, 8'h00, RESP_OKAY);
		i_usf_line_partner.nbits = 8;
		d = xs();
		sendTx(d[7:0]);
		sendTx(d[15:8]);
		waitGot(2);
		popChk({2'b10, d[7:0]}, "first queued word");
		popChk({2'b10, d[15:8]}, "second queued word");
		rdChk(ADDR_STATUS, 8'hc0, 8'hc0, "transmit flags after frame");
		// Transmit-empty interrupt, open then masked
		axiWrite(ADDR_CTRL2, 8'h8c, RESP_OKAY);
		globalIrqMask <= 1'b0;
		repeat (3) @(posedge mclk);
		check({31'h0, irqReq}, 32'h1, "empty interrupt missing");
		globalIrqMask <= 1'b1;
		repeat (3) @(posedge mclk);
		check({31'h0, irqReq}, 32'h0, "masked interrupt seen");
		// Receive path
		axiWrite(ADDR_CTRL2, 8'h2c, RESP_OKAY);
		globalIrqMask <= 1'b0;
		d = xs();
		rxByte(d[7:0], 1'b1);
		check({31'h0, irqReq}, 32'h1, "receive interrupt missing");
		rdChk(ADDR_STATUS, 8'h2b, 8'h20, "receive full");
		rdChk(ADDR_DATA, 8'hff, d[7:0], "received byte");
		rdChk(ADDR_STATUS, 8'h20, 8'h00, "full not cleared");
		repeat (200) @(posedge mclk);
		rdChk(ADDR_STATUS, 8'h10, 8'h10, "idle line flag");
		axiRead(ADDR_DATA, d, r);
		d = xs();
		rxByte(d[7:0], 1'b1);
		rxByte(d[15:8], 1'b1);
		rdChk(ADDR_STATUS, 8'h28, 8'h28, "overrun flag");
		rdChk(ADDR_DATA, 8'hff, d[7:0], "buffer kept on overrun");
		rdChk(ADDR_STATUS, 8'h08, 8'h00, "overrun not cleared");
		rxByte(d[23:16], 1'b0);
		rdChk(ADDR_STATUS, 8'h22, 8'h22, "missing stop");
		rdChk(ADDR_DATA, 8'hff, d[23:16], "data kept on framing fault");
		rxByte(8'h00, 1'b0);
		rdChk(ADDR_STATUS, 8'h02, 8'h02, "break not framing");
		axiRead(ADDR_DATA, d, r);
		// Nine-bit receive keeps its top bit, then a wrong parity bit is flagged
		axiWrite(ADDR_CTRL1, 8'h10, RESP_OKAY);
		d = xs();
		@(posedge mclk);
		i_usf_line_partner.send_frame({1'b1, d[7:0]}, 9, 1'b1);
		repeat (20) @(posedge mclk);
		rdChk(ADDR_CTRL1, 8'h80, 8'h80, "ninth bit not received");
		rdChk(ADDR_STATUS, 8'h21, 8'h20, "nine-bit word not full");
		rdChk(ADDR_DATA, 8'hff, d[7:0], "nine-bit data");
		axiWrite(ADDR_CTRL1, 8'h04, RESP_OKAY);
		@(posedge mclk);
		i_usf_line_partner.send_frame({1'b0, ~^d[14:8], d[14:8]}, 8, 1'b1);
		repeat (20) @(posedge mclk);
		rdChk(ADDR_STATUS, 8'h21, 8'h21, "parity error missed");
		axiRead(ADDR_DATA, d, r);
		// Break frames, then one mark
		axiWrite(ADDR_CTRL2, 8'h0d, RESP_OKAY);
		waitGot(1);
		popChk(10'h000, "break frame");
		repeat (300) @(posedge mclk);
		check({31'h0, serialOut}, 32'h0, "break not continuous");
		axiWrite(ADDR_CTRL2, 8'h0c, RESP_OKAY);
		t = 0;
		while (serialOut !== 1'b1 && t < 400) begin
			@(posedge mclk);
			t++;
		end
		check({31'h0, serialOut}, 32'h1, "no mark after break");
		// Slower rates: transmit cell of 16 x 3 x 2 clocks, receive cell of 16 x 3
		axiWrite(ADDR_BAUD, 8'h05, RESP_OKAY);
		sendTx(8'h01);
		t = 0;
		while (serialOut !== 1'b0 && t < 2000) begin
			@(posedge mclk);
			t++;
		end
		t = 0;
		while (serialOut === 1'b0 && t < 2000) begin
			@(posedge mclk);
			t++;
		end
		check(t, {21'h0, PRE_1} << 5, "transmit cell length");
		i_usf_line_partner.bitClks = 48;
		d = xs();
		rxByte(d[7:0], 1'b1);
		rdChk(ADDR_STATUS, 8'h22, 8'h20, "slow receive not clean");
		rdChk(ADDR_DATA, 8'hff, d[7:0], "slow receive data");
		reportAndStop();
	end
endmodule
